// [verilog/oopaf_pkg.sv]
// Package for the four-pin output-only port with alternate functions.
// Assumes an APB master with 32-bit data; registers sit at word index * 4.
`default_nettype none
package oopaf_pkg;
   localparam int OOPAF_PINS = 4;
   localparam int OOPAF_ADDR_W = 20;
   // Register indices; byte address is four times the index
   localparam logic [15:0] OOPAF_IDX_DATA = 16'hf228;
   localparam logic [15:0] OOPAF_IDX_DRV_LO = 16'hf22a;
   localparam logic [15:0] OOPAF_IDX_DRV_HI = 16'hf22b;
   localparam logic [15:0] OOPAF_IDX_FSEL_LO = 16'hf22c;
   localparam logic [15:0] OOPAF_IDX_FSEL_HI = 16'hf22d;
   // Field layout: writable bits 3..0 of each byte
   localparam int OOPAF_FIELD_LSB = 0;
   localparam int OOPAF_FIELD_W = 4;
   localparam int OOPAF_HI_BYTE_LSB = 8;
   // Reset values
   localparam logic [3:0] OOPAF_DATA_RST = 4'h0;
   localparam logic [3:0] OOPAF_DRV_RST = 4'h0;
   localparam logic [3:0] OOPAF_FSEL_RST = 4'h0;
   // Drive-state codes {high bit, low bit}
   localparam logic [1:0] OOPAF_DRV_HIZ = 2'h0;
   localparam logic [1:0] OOPAF_DRV_PCH = 2'h1;
   localparam logic [1:0] OOPAF_DRV_NCH = 2'h2;
   localparam logic [1:0] OOPAF_DRV_CMOS = 2'h3;
   // Function codes {high bit, low bit}
   localparam logic [1:0] OOPAF_FN_GPIO = 2'h0;
   localparam logic [1:0] OOPAF_FN_ONE = 2'h1;
   localparam logic [1:0] OOPAF_FN_TWO = 2'h2;
   localparam logic [1:0] OOPAF_FN_THREE = 2'h3;
endpackage
`default_nettype wire

// [verilog/oopaf_port.sv]
// Four-pin output-only port with selectable drive state and pin function.
// Assumes an APB master on pclk and alternate sources from logic on pclk.
//
// Functional notes
// - Two-bit drive code: hiz, P-drain, N-drain, CMOS
// - Pin3 function: data, reserved, timer two, PWM four
// - Pin2 function: data, reserved, timer one, PWM three
// - Pin1 function: data, fast clock, PWM two, reserved
// - Pin0 function: data, slow clock, PWM one, reserved
// - Function select registers reset to zero
// - Output only, no direction or input path
// - Reset puts every pin in high impedance
// - General function drives the data bit level
// - Function select by byte or word; upper bits zero
// - Low register gives code bit0, high gives bit1
// - Data register four bits, readable, resets zero
`timescale 1ns/1ps
`default_nettype none
module oopaf_port
   import oopaf_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [OOPAF_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic slow_clock_out,
   input wire logic fast_clock_out,
   input wire logic timer_first_out,
   input wire logic timer_second_out,
   input wire logic pwm_ch_first,
   input wire logic pwm_ch_second,
   input wire logic pwm_ch_third,
   input wire logic pwm_ch_fourth,
   output logic [OOPAF_PINS-1:0] pin_out,
   output logic [OOPAF_PINS-1:0] pin_oe
);
   logic [3:0] port_out_data_reg_ff, nxt_port_out_data_reg;
   logic [3:0] drive_state_select_low_ff, nxt_drive_state_select_low;
   logic [3:0] drive_state_select_high_ff, nxt_drive_state_select_high;
   logic [3:0] pin_function_select_low_ff, nxt_pin_function_select_low;
   logic [3:0] pin_function_select_high_ff, nxt_pin_function_select_high;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready;
   logic pslverr_ff, nxt_pslverr;
   logic [OOPAF_PINS-1:0] pin_out_ff, nxt_pin_out;
   logic [OOPAF_PINS-1:0] pin_oe_ff, nxt_pin_oe;
   logic [OOPAF_PINS-1:0] src_level;
   logic [15:0] word_idx;
   logic setup_ph;
   logic wr_acc;
   logic hit_data, hit_drv_lo, hit_drv_hi, hit_fsel_lo, hit_fsel_hi;

   assign word_idx = paddr[17:2];
   assign setup_ph = psel & ~penable;
   // Write commits only at the access edge where pready is high
   assign wr_acc = psel & penable & pwrite & pready_ff;

   always_comb begin
      hit_data = 1'b0;
      hit_drv_lo = 1'b0;
      hit_drv_hi = 1'b0;
      hit_fsel_lo = 1'b0;
      hit_fsel_hi = 1'b0;
      if (paddr[1:0] != 2'h0 || paddr[OOPAF_ADDR_W-1:18] != 2'h0) begin
         hit_data = 1'b0;
      end else if (word_idx == OOPAF_IDX_DATA) begin
         hit_data = 1'b1;
      end else if (word_idx == OOPAF_IDX_DRV_LO) begin
         hit_drv_lo = 1'b1;
      end else if (word_idx == OOPAF_IDX_DRV_HI) begin
         hit_drv_hi = 1'b1;
      end else if (word_idx == OOPAF_IDX_FSEL_LO) begin
         hit_fsel_lo = 1'b1;
      end else if (word_idx == OOPAF_IDX_FSEL_HI) begin
         hit_fsel_hi = 1'b1;
      end
   end

   // Register writes; the lower address of each pair also takes a 16-bit word
   always_comb begin
      nxt_port_out_data_reg = port_out_data_reg_ff;
      nxt_drive_state_select_low = drive_state_select_low_ff;
      nxt_drive_state_select_high = drive_state_select_high_ff;
      nxt_pin_function_select_low = pin_function_select_low_ff;
      nxt_pin_function_select_high = pin_function_select_high_ff;
      if (wr_acc) begin
         if (hit_data && pstrb[0]) begin
            nxt_port_out_data_reg = pwdata[3:0];
         end
         if (hit_drv_lo && pstrb[0]) begin
            nxt_drive_state_select_low = pwdata[3:0];
         end
         if ((hit_drv_lo && pstrb[1])) begin
            nxt_drive_state_select_high = pwdata[11:8];
         end else if (hit_drv_hi && pstrb[0]) begin
            nxt_drive_state_select_high = pwdata[3:0];
         end
         if (hit_fsel_lo && pstrb[0]) begin
            nxt_pin_function_select_low = pwdata[3:0];
         end
         if (hit_fsel_lo && pstrb[1]) begin
            nxt_pin_function_select_high = pwdata[11:8];
         end else if (hit_fsel_hi && pstrb[0]) begin
            nxt_pin_function_select_high = pwdata[3:0];
         end
      end
   end

   // Answer is prepared in the setup cycle, so every access has no wait state
   always_comb begin
      nxt_pready = 1'b0;
      nxt_pslverr = 1'b0;
      nxt_prdata = 32'h0000_0000;
      if (setup_ph) begin
         nxt_pready = 1'b1;
         if (hit_data) begin
            nxt_prdata = {28'h000_0000, port_out_data_reg_ff};
         end else if (hit_drv_lo) begin
            nxt_prdata = {20'h0_0000, drive_state_select_high_ff, 4'h0,
                          drive_state_select_low_ff};
         end else if (hit_drv_hi) begin
            nxt_prdata = {28'h000_0000, drive_state_select_high_ff};
         end else if (hit_fsel_lo) begin
            nxt_prdata = {20'h0_0000, pin_function_select_high_ff, 4'h0,
                          pin_function_select_low_ff};
         end else if (hit_fsel_hi) begin
            nxt_prdata = {28'h000_0000, pin_function_select_high_ff};
         end else begin
            nxt_pslverr = 1'b1;
         end
      end
   end

   // Alternate source per pin; reserved codes fall back to the data bit
   always_comb begin
      src_level = port_out_data_reg_ff;
      case ({pin_function_select_high_ff[0], pin_function_select_low_ff[0]})
         OOPAF_FN_ONE: src_level[0] = slow_clock_out;
         OOPAF_FN_TWO: src_level[0] = pwm_ch_first;
         default: src_level[0] = port_out_data_reg_ff[0];
      endcase
      case ({pin_function_select_high_ff[1], pin_function_select_low_ff[1]})
         OOPAF_FN_ONE: src_level[1] = fast_clock_out;
         OOPAF_FN_TWO: src_level[1] = pwm_ch_second;
         default: src_level[1] = port_out_data_reg_ff[1];
      endcase
      case ({pin_function_select_high_ff[2], pin_function_select_low_ff[2]})
         OOPAF_FN_TWO: src_level[2] = timer_first_out;
         OOPAF_FN_THREE: src_level[2] = pwm_ch_third;
         default: src_level[2] = port_out_data_reg_ff[2];
      endcase
      case ({pin_function_select_high_ff[3], pin_function_select_low_ff[3]})
         OOPAF_FN_TWO: src_level[3] = timer_second_out;
         OOPAF_FN_THREE: src_level[3] = pwm_ch_fourth;
         default: src_level[3] = port_out_data_reg_ff[3];
      endcase
   end

   // Open-drain modes drive only one level and release the pin otherwise
   always_comb begin
      nxt_pin_out = '0;
      nxt_pin_oe = '0;
      for (int i = 0; i < OOPAF_PINS; i++) begin
         case ({drive_state_select_high_ff[i], drive_state_select_low_ff[i]})
            OOPAF_DRV_PCH: begin
               nxt_pin_out[i] = 1'b1;
               nxt_pin_oe[i] = src_level[i];
            end
            OOPAF_DRV_NCH: begin
               nxt_pin_out[i] = 1'b0;
               nxt_pin_oe[i] = ~src_level[i];
            end
            OOPAF_DRV_CMOS: begin
               nxt_pin_out[i] = src_level[i];
               nxt_pin_oe[i] = 1'b1;
            end
            default: begin
               nxt_pin_out[i] = 1'b0;
               nxt_pin_oe[i] = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_out_data_reg_ff <= OOPAF_DATA_RST;
         drive_state_select_low_ff <= OOPAF_DRV_RST;
         drive_state_select_high_ff <= OOPAF_DRV_RST;
         pin_function_select_low_ff <= OOPAF_FSEL_RST;
         pin_function_select_high_ff <= OOPAF_FSEL_RST;
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         pin_out_ff <= '0;
         pin_oe_ff <= '0;
      end else begin
         port_out_data_reg_ff <= nxt_port_out_data_reg;
         drive_state_select_low_ff <= nxt_drive_state_select_low;
         drive_state_select_high_ff <= nxt_drive_state_select_high;
         pin_function_select_low_ff <= nxt_pin_function_select_low;
         pin_function_select_high_ff <= nxt_pin_function_select_high;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         pin_out_ff <= nxt_pin_out;
         pin_oe_ff <= nxt_pin_oe;
      end
   end

   // No input path exists: pins are driven only, never sampled
   assign pin_out = pin_out_ff;
   assign pin_oe = pin_oe_ff;
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;

   logic [3:0] fcode_any;
   assign fcode_any = pin_function_select_low_ff | pin_function_select_high_ff;

   property p_reset_state;
      @(posedge pclk) disable iff (!presetn)
      !$past(presetn) |-> (pin_oe_ff == '0 && fcode_any == 4'h0 &&
                           port_out_data_reg_ff == 4'h0);
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("port not idle after reset");

   property p_hiz_release;
      @(posedge pclk) disable iff (!presetn)
      (drive_state_select_low_ff[0] == 1'b0 && drive_state_select_high_ff[0] == 1'b0)
         |=> !pin_oe_ff[0];
   endproperty
   a_hiz_release: assert property (p_hiz_release)
      else $error("pin0 driven in high impedance state");

   property p_nch_low;
      @(posedge pclk) disable iff (!presetn)
      (drive_state_select_high_ff[1] && !drive_state_select_low_ff[1] &&
       fcode_any[1] == 1'b0 && !port_out_data_reg_ff[1])
         |=> (pin_oe_ff[1] && !pin_out_ff[1]);
   endproperty
   a_nch_low: assert property (p_nch_low)
      else $error("N-drain pin1 not pulling low");

   property p_pch_high;
      @(posedge pclk) disable iff (!presetn)
      (!drive_state_select_high_ff[2] && drive_state_select_low_ff[2] &&
       fcode_any[2] == 1'b0)
         |=> (pin_oe_ff[2] == $past(port_out_data_reg_ff[2]) && pin_out_ff[2]);
   endproperty
   a_pch_high: assert property (p_pch_high)
      else $error("P-drain pin2 wrong");

   property p_cmos_slow;
      @(posedge pclk) disable iff (!presetn)
      (drive_state_select_high_ff[0] && drive_state_select_low_ff[0] &&
       !pin_function_select_high_ff[0] && pin_function_select_low_ff[0])
         |=> (pin_oe_ff[0] && pin_out_ff[0] == $past(slow_clock_out));
   endproperty
   a_cmos_slow: assert property (p_cmos_slow)
      else $error("pin0 not following slow clock");

   property p_cmos_pwm_fourth;
      @(posedge pclk) disable iff (!presetn)
      (drive_state_select_high_ff[3] && drive_state_select_low_ff[3] &&
       pin_function_select_high_ff[3] && pin_function_select_low_ff[3])
         |=> (pin_oe_ff[3] && pin_out_ff[3] == $past(pwm_ch_fourth));
   endproperty
   a_cmos_pwm_fourth: assert property (p_cmos_pwm_fourth)
      else $error("pin3 not following fourth PWM");

   property p_read_upper_zero;
      @(posedge pclk) disable iff (!presetn)
      pready_ff |-> (prdata_ff[31:12] == 20'h0_0000 && prdata_ff[7:4] == 4'h0);
   endproperty
   a_read_upper_zero: assert property (p_read_upper_zero)
      else $error("reserved read bits not zero");

   property p_fsel_word;
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && hit_fsel_lo && pstrb[1:0] == 2'h3)
         |=> (pin_function_select_high_ff == $past(pwdata[11:8]) &&
              pin_function_select_low_ff == $past(pwdata[3:0]));
   endproperty
   a_fsel_word: assert property (p_fsel_word)
      else $error("function select word write lost");

   property p_data_rw;
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && hit_data && pstrb[0]) ##1 (psel && !penable && hit_data)
         |=> (pready_ff && prdata_ff[3:0] == $past(port_out_data_reg_ff));
   endproperty
   a_data_rw: assert property (p_data_rw)
      else $error("data register readback wrong");

   property p_one_cycle_ready;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> (pready_ff ##1 !pready_ff || (psel && !penable));
   endproperty
   a_one_cycle_ready: assert property (p_one_cycle_ready)
      else $error("ready not a single cycle");
endmodule
`default_nettype wire

// [testbench/oopaf_led_load.sv]
// External loads on the port pins: an LED from the supply into each pin.
// Assumes pin_oe high means the port drives pin_out onto the pin.
`timescale 1ns/1ps
`default_nettype none
module oopaf_led_load
   import oopaf_pkg::*;
(
   input wire logic [OOPAF_PINS-1:0] pin_out,
   input wire logic [OOPAF_PINS-1:0] pin_oe,
   output logic [OOPAF_PINS-1:0] pin_level,
   output logic [OOPAF_PINS-1:0] led_on
);
   // A released pin is pulled to the supply, never left at a stale level
   assign pin_level = (pin_oe & pin_out) | ~pin_oe;
   // The LED sinks into the pin, so it lights only on a driven low
   assign led_on = ~pin_level;
endmodule
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the output-only port: APB tasks and pin checks.
// Assumes the port answers APB with zero wait states and a LED load per pin.
`timescale 1ns/1ps
`default_nettype none
module tb
   import oopaf_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [OOPAF_ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic [7:0] src = 8'h00;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] pin_out;
   logic [3:0] pin_oe;
   logic [3:0] pin_level;
   logic [3:0] led_on;
   int miscompares = 0;
   int samples_checked = 0;
   logic [7:0] pats [6] = '{8'h55, 8'haa, 8'h33, 8'hcc, 8'h0f, 8'hf0};
   // Function settings that use legal codes only: all data, then each alternate in turn
   logic [3:0] fls [3] = '{4'h0, 4'h3, 4'hc};
   logic [3:0] fhs [3] = '{4'h0, 4'hc, 4'hf};
   logic [3:0] dv;
   logic [31:0] rd;
   logic er;

   always #5 pclk = ~pclk;

   oopaf_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .slow_clock_out(src[0]), .fast_clock_out(src[1]),
      .timer_first_out(src[2]), .timer_second_out(src[3]), .pwm_ch_first(src[4]),
      .pwm_ch_second(src[5]), .pwm_ch_third(src[6]), .pwm_ch_fourth(src[7]),
      .pin_out(pin_out), .pin_oe(pin_oe));

   oopaf_led_load u_load (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level),
      .led_on(led_on));

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
      input logic [3:0] st, input logic keep, output logic [31:0] rdv, output logic err);
      int n;
      n = 0;
      // Entered just after a rising edge with penable already low
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= OOPAF_ADDR_W'({idx, 2'b00});
      pwdata <= wd;
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      // Answer is taken at the same edge that saw pready high
      rdv = prdata;
      err = pslverr;
      if (n >= 20) chk("pready", 32'h0000_0001, 32'h0000_0000);
      penable <= 1'b0;
      // With keep set the next setup cycle follows at once, so psel stays up
      if (!keep) begin
         psel <= 1'b0;
         @(posedge pclk);
      end
   endtask

   task automatic wr(input logic [15:0] idx, input logic [31:0] wd, input logic [3:0] st);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx, wd, st, 1'b0, r, e);
   endtask

   task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, idx, 32'h0000_0000, 4'h0, 1'b0, r, e);
      chk("prdata", exp, r);
   endtask

   function automatic logic [7:0] exp_pins(input logic [1:0] dc, input logic [3:0] fl,
      input logic [3:0] fh, input logic [3:0] d, input logic [7:0] s);
      logic [3:0] o;
      logic [3:0] e;
      logic lv;
      logic [1:0] fc;
      for (int i = 0; i < 4; i++) begin
         lv = d[i];
         fc = {fh[i], fl[i]};
         if ((i < 2 && fc == OOPAF_FN_ONE) || (i >= 2 && fc == OOPAF_FN_TWO)) lv = s[i];
         if ((i < 2 && fc == OOPAF_FN_TWO) || (i >= 2 && fc == OOPAF_FN_THREE)) lv = s[i+4];
         case (dc)
            OOPAF_DRV_HIZ: {e[i], o[i]} = 2'b00;
            OOPAF_DRV_PCH: {e[i], o[i]} = {lv, 1'b1};
            OOPAF_DRV_NCH: {e[i], o[i]} = {~lv, 1'b0};
            default: {e[i], o[i]} = {1'b1, lv};
         endcase
      end
      return {e, o};
   endfunction

   task automatic reset_checks();
      rdchk(OOPAF_IDX_DATA, 32'h0000_0000);
      rdchk(OOPAF_IDX_DRV_LO, 32'h0000_0000);
      rdchk(OOPAF_IDX_DRV_HI, 32'h0000_0000);
      rdchk(OOPAF_IDX_FSEL_LO, 32'h0000_0000);
      rdchk(OOPAF_IDX_FSEL_HI, 32'h0000_0000);
      chk("pin_oe", 32'h0000_0000, {28'h0, pin_oe});
      $display("test reset done");
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #200_000;
      miscompares++;
      final_report();
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      reset_checks();
      // Write then read back to back, with no idle cycle between them
      apb(1'b1, OOPAF_IDX_DATA, 32'hffff_ffff, 4'hf, 1'b1, rd, er);
      rdchk(OOPAF_IDX_DATA, 32'h0000_000f);
      // Function values keep every pin on a legal code
      wr(OOPAF_IDX_FSEL_LO, 32'hffff_fef5, 4'h3);
      rdchk(OOPAF_IDX_FSEL_LO, 32'h0000_0e05);
      wr(OOPAF_IDX_FSEL_HI, 32'h0000_00f4, 4'h1);
      rdchk(OOPAF_IDX_FSEL_LO, 32'h0000_0405);
      wr(OOPAF_IDX_FSEL_LO, 32'h0000_0300, 4'h1);
      rdchk(OOPAF_IDX_FSEL_HI, 32'h0000_0004);
      apb(1'b0, 16'h0100, 32'h0000_0000, 4'h0, 1'b0, rd, er);
      chk("pslverr", 32'h0000_0001, {31'h0, er});
      $display("test registers done");
      for (int dc = 0; dc < 4; dc++) begin
         for (int f = 0; f < 3; f++) begin
            wr(OOPAF_IDX_DRV_LO, {20'h0, {4{dc[1]}}, 4'h0, {4{dc[0]}}}, 4'h3);
            wr(OOPAF_IDX_FSEL_LO, {20'h0, fhs[f], 4'h0, fls[f]}, 4'h3);
            for (int j = 0; j < 2; j++) begin
               dv = (j == 0) ? 4'h5 : 4'ha;
               wr(OOPAF_IDX_DATA, {28'h0, dv}, 4'h1);
               foreach (pats[k]) begin
                  src <= pats[k];
                  repeat (3) @(posedge pclk);
                  chk("pins", {24'h0, exp_pins(dc[1:0], fls[f], fhs[f], dv, pats[k])},
                     {24'h0, pin_oe, pin_out});
               end
            end
         end
      end
      $display("test pin modes done");
      wr(OOPAF_IDX_FSEL_LO, 32'h0000_0000, 4'h3);
      wr(OOPAF_IDX_DRV_LO, 32'h0000_0f00, 4'h3);
      wr(OOPAF_IDX_DATA, 32'h0000_0006, 4'h1);
      repeat (3) @(posedge pclk);
      chk("led_on", 32'h0000_0009, {28'h0, led_on});
      $display("test led drive done");
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      reset_checks();
      final_report();
   end
endmodule
`default_nettype wire
